// *** verilog/rtsb_cfg.svh ***
// constants for the terminal status bits and bus select block
`ifndef RTSB_CFG_SVH
`define RTSB_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RTSB_OFF_STATUS 16'h001a
`define RTSB_OFF_CURMSG 16'h001b
`define RTSB_OFF_BUSA 16'h001c

// ----------------------------------------
// status bits register layout
// ----------------------------------------
`define RTSB_BIT_TXCLR 15
`define RTSB_BIT_MSGERR 10
`define RTSB_BIT_BCAST 4
`define RTSB_BIT_BUSY 3
`define RTSB_BIT_SSF 2
`define RTSB_BIT_BUS_CONTROL_ACCEPT_FLAG 1
`define RTSB_BIT_TFLAG 0
`define RTSB_HOST_WR_MASK 16'h830f
`define RTSB_TXCLR_MASK 16'h83ef
`define RTSB_RESET_WORD 16'h0000

// ----------------------------------------
// mode codes and timing
// ----------------------------------------
`define RTSB_MC_VECTOR 5'h10
`define RTSB_MC_SHUTDOWN 5'h14
`define RTSB_MC_OVERRIDE 5'h15
`define RTSB_CLK_KHZ 25000
`define RTSB_UPDATE_DELAY_NS 5000
`define RTSB_UPDATE_DELAY_CYC ((`RTSB_UPDATE_DELAY_NS * `RTSB_CLK_KHZ) / 1000000)
`define RTSB_TIMER_W 8

`endif

// *** verilog/rtsb_pkg.sv ***
// types shared by the terminal status bits block
package rtsb_pkg;
    typedef logic [15:0] rtsb_word_t;
    typedef logic [4:0] rtsb_mode_code_t;
    typedef enum logic [1:0] {
        RTSB_TMR_IDLE = 2'b01,
        RTSB_TMR_RUN = 2'b10
    } rtsb_tmr_state_t;
endpackage

// *** verilog/rtsb_update_timer.sv ***
// delayed load of the current message pointer after a valid command
`timescale 1ns/10ps
`include "rtsb_cfg.svh"
module rtsb_update_timer (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic start_i,
    input wire rtsb_pkg::rtsb_word_t addr_i,
    output logic load_o,
    output rtsb_pkg::rtsb_word_t addr_o
);
    import rtsb_pkg::*;

    localparam logic [`RTSB_TIMER_W-1:0] LAST_CNT =
        `RTSB_TIMER_W'(`RTSB_UPDATE_DELAY_CYC - 1);

    rtsb_tmr_state_t state_reg;
    logic [`RTSB_TIMER_W-1:0] cnt_reg;
    rtsb_word_t addr_reg;

    // a new command restarts the wait with its own address
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= RTSB_TMR_IDLE;
            cnt_reg <= '0;
        end else if (start_i) begin
            state_reg <= RTSB_TMR_RUN;
            cnt_reg <= '0;
        end else begin
            case (state_reg)
                RTSB_TMR_IDLE: begin
                    cnt_reg <= '0;
                end
                RTSB_TMR_RUN: begin
                    if (cnt_reg == LAST_CNT) begin
                        state_reg <= RTSB_TMR_IDLE;
                    end
                    cnt_reg <= cnt_reg + 1'b1;
                end
                default: begin
                    state_reg <= RTSB_TMR_IDLE;
                end
            endcase
        end
    end

    // address captured with the start pulse
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            addr_reg <= '0;
        end else if (start_i) begin
            addr_reg <= addr_i;
        end
    end

    // load fires in the cycle the full delay has elapsed
    assign load_o = (state_reg == RTSB_TMR_RUN) && (cnt_reg == LAST_CNT) && !start_i;
    assign addr_o = addr_reg;
endmodule

// *** verilog/rtsb_shutdown_ctl.sv ***
// automatic shutdown and override of inactive bus a
`timescale 1ns/10ps
`include "rtsb_cfg.svh"
module rtsb_shutdown_ctl (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic mode_data_valid_i,
    input wire rtsb_pkg::rtsb_mode_code_t mode_code_i,
    input wire logic cmd_on_bus_b_i,
    input wire rtsb_pkg::rtsb_word_t mode_data_i,
    input wire rtsb_pkg::rtsb_word_t select_value_i,
    input wire logic auto_shutdown_disable_i,
    output logic tx_shutdown_a_flag_o
);
    import rtsb_pkg::*;

    logic qualify;
    logic flag_reg;

    // command on bus b, enabled, and data equal to select value
    assign qualify = mode_data_valid_i && !auto_shutdown_disable_i
        && cmd_on_bus_b_i
        && (mode_data_i == select_value_i);

    // shutdown sets, override clears
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flag_reg <= 1'b0;
        end else if (qualify && (mode_code_i == `RTSB_MC_SHUTDOWN)) begin
            flag_reg <= 1'b1;
        end else if (qualify && (mode_code_i == `RTSB_MC_OVERRIDE)) begin
            flag_reg <= 1'b0;
        end
    end

    assign tx_shutdown_a_flag_o = flag_reg;
endmodule

// *** verilog/rtsb_top.sv ***
// status word bits, current message pointer and bus a select registers
`timescale 1ns/10ps
`include "rtsb_cfg.svh"
module rtsb_top (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic terminal_soft_reset_i,
    // host register port
    input wire rtsb_pkg::rtsb_word_t host_addr_i,
    input wire logic host_wr_i,
    input wire logic host_rd_i,
    input wire rtsb_pkg::rtsb_word_t host_wdata_i,
    output rtsb_pkg::rtsb_word_t host_rdata_o,
    // configuration bits
    input wire logic vector_word_option_i,
    input wire logic auto_shutdown_disable_i,
    input wire logic busy_interrupt_option_i,
    input wire logic subsystem_fail_pin_i,
    // command decode side
    input wire logic cmd_valid_i,
    input wire rtsb_pkg::rtsb_word_t cmd_buf_addr_i,
    input wire logic cmd_transmit_i,
    input wire logic cmd_is_mode_i,
    input wire rtsb_pkg::rtsb_mode_code_t mode_code_i,
    input wire logic cmd_on_bus_b_i,
    input wire logic desc_busy_i,
    // mode data word for shutdown commands
    input wire logic mode_data_valid_i,
    input wire rtsb_pkg::rtsb_word_t mode_data_i,
    // status word and message completion
    input wire logic status_sent_i,
    input wire logic status_repeat_i,
    input wire logic msg_done_i,
    input wire logic msg_broadcast_i,
    input wire logic msg_error_i,
    // outputs to the responder
    output logic [10:0] status_word_bits_o,
    output logic resp_busy_o,
    output logic suppress_data_o,
    output logic message_was_busy_flag_o,
    output logic irq_was_busy_flag_o,
    output logic tx_shutdown_a_flag_o,
    output rtsb_pkg::rtsb_word_t current_message_pointer_o
);
    import rtsb_pkg::*;

    // ----------------------------------------
    // register storage
    // ----------------------------------------
    rtsb_word_t status_reg;
    rtsb_word_t curmsg_reg;
    rtsb_word_t busa_reg;
    rtsb_word_t rdata_reg;
    logic busy_cmd_reg;
    logic was_busy_reg;
    logic irq_was_busy_reg;

    // ----------------------------------------
    // decode of host accesses
    // ----------------------------------------
    logic wr_status;
    logic wr_curmsg;
    logic wr_busa;

    assign wr_status = host_wr_i && (host_addr_i == `RTSB_OFF_STATUS);
    assign wr_curmsg = host_wr_i && (host_addr_i == `RTSB_OFF_CURMSG);
    assign wr_busa = host_wr_i && (host_addr_i == `RTSB_OFF_BUSA);

    // ----------------------------------------
    // command classification
    // ----------------------------------------
    logic mode_has_data;
    logic vector_cmd;
    logic tx_clear_evt;
    logic busy_now;

    // mode codes 16-31 that send a data word
    assign mode_has_data = cmd_is_mode_i && mode_code_i[4] && cmd_transmit_i;

    // vector word command clears subsystem bit when option is zero
    assign vector_cmd = cmd_valid_i && cmd_is_mode_i
        && (mode_code_i == `RTSB_MC_VECTOR) && !vector_word_option_i;

    // status repeats for transmit-status type commands leave bits alone
    assign tx_clear_evt = status_sent_i && !status_repeat_i
        && status_reg[`RTSB_BIT_TXCLR];

    // global or per-command busy
    assign busy_now = status_reg[`RTSB_BIT_BUSY]
        || desc_busy_i;

    // ----------------------------------------
    // status word bits register, host half
    // ----------------------------------------
    rtsb_word_t host_next;

    // start from stored value, apply device clears, then host write
    always_comb begin
        host_next = status_reg & `RTSB_HOST_WR_MASK;
        if (tx_clear_evt) begin
            host_next = host_next & ~`RTSB_TXCLR_MASK;
        end
        if (vector_cmd) begin
            host_next[`RTSB_BIT_SSF] = 1'b0;
        end
        if (wr_status) begin
            // reserved positions never take host data
            host_next = host_wdata_i & `RTSB_HOST_WR_MASK;
        end
    end

    // device-maintained bits live in the same register word
    logic msgerr_next;
    logic bcast_next;

    always_comb begin
        msgerr_next = status_reg[`RTSB_BIT_MSGERR];
        bcast_next = status_reg[`RTSB_BIT_BCAST];
        if (msg_done_i) begin
            msgerr_next = msg_error_i;
            bcast_next = msg_broadcast_i;
        end
    end

    // master and soft reset both clear the status bits
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            status_reg <= `RTSB_RESET_WORD;
        end else if (terminal_soft_reset_i) begin
            status_reg <= `RTSB_RESET_WORD;
        end else begin
            status_reg <= host_next;
            status_reg[`RTSB_BIT_MSGERR] <= msgerr_next;
            status_reg[`RTSB_BIT_BCAST] <= bcast_next;
        end
    end

    // ----------------------------------------
    // outgoing status word bits
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 11; gi = gi + 1) begin : g_sw
            if (gi == `RTSB_BIT_SSF) begin : g_ssf
                // register bit or external fail pin
                assign status_word_bits_o[gi] =
                    status_reg[gi] || subsystem_fail_pin_i;
            end else if (gi == `RTSB_BIT_BUSY) begin : g_busy
                assign status_word_bits_o[gi] = busy_cmd_reg;
            end else begin : g_plain
                assign status_word_bits_o[gi] = status_reg[gi];
            end
        end
    endgenerate

    // ----------------------------------------
    // busy tracking for the current message
    // ----------------------------------------

    // busy decision latched when the command is accepted
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy_cmd_reg <= 1'b0;
        end else if (cmd_valid_i) begin
            busy_cmd_reg <= busy_now;
        end
    end

    // was-busy for the stored message info word
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            was_busy_reg <= 1'b0;
            irq_was_busy_reg <= 1'b0;
        end else if (msg_done_i) begin
            was_busy_reg <= busy_cmd_reg;
            irq_was_busy_reg <= busy_cmd_reg && busy_interrupt_option_i;
        end
    end

    // busy marks info words; the irq was-busy flag is raised only when the busy interrupt option is set
    assign message_was_busy_flag_o = was_busy_reg;
    assign irq_was_busy_flag_o = irq_was_busy_reg;

    // busy level for the response in progress
    assign resp_busy_o = cmd_valid_i ? busy_now : busy_cmd_reg;

    // ----------------------------------------
    // data word suppression
    // ----------------------------------------
    logic sup_busy;
    logic sup_flag;

    // busy transmit response carries status only
    assign sup_busy = resp_busy_o && cmd_transmit_i;

    // terminal flag drops data of transmit subaddress and data mode codes
    assign sup_flag = status_reg[`RTSB_BIT_TFLAG]
        && ((cmd_transmit_i && !cmd_is_mode_i) || mode_has_data);

    assign suppress_data_o = sup_busy || sup_flag;

    // ----------------------------------------
    // current message pointer
    // ----------------------------------------
    logic ptr_load;
    rtsb_word_t ptr_addr;

    rtsb_update_timer u_timer (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .start_i(cmd_valid_i),
        .addr_i(cmd_buf_addr_i),
        .load_o(ptr_load),
        .addr_o(ptr_addr)
    );

    // only master reset clears it; soft reset leaves it alone
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            curmsg_reg <= '0;
        end else if (ptr_load) begin
            curmsg_reg <= ptr_addr;
        end else if (wr_curmsg) begin
            curmsg_reg <= host_wdata_i;
        end
    end

    assign current_message_pointer_o = curmsg_reg;

    // ----------------------------------------
    // bus a select register
    // ----------------------------------------

    // cleared by master reset only
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busa_reg <= '0;
        end else if (wr_busa) begin
            busa_reg <= host_wdata_i;
        end
    end

    rtsb_shutdown_ctl u_shutdown (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .mode_data_valid_i(mode_data_valid_i && cmd_is_mode_i),
        .mode_code_i(mode_code_i),
        .cmd_on_bus_b_i(cmd_on_bus_b_i),
        .mode_data_i(mode_data_i),
        .select_value_i(busa_reg),
        .auto_shutdown_disable_i(auto_shutdown_disable_i),
        .tx_shutdown_a_flag_o(tx_shutdown_a_flag_o)
    );

    // ----------------------------------------
    // host read data
    // ----------------------------------------

    // registered read, unmapped addresses return zero
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_reg <= '0;
        end else if (host_rd_i) begin
            case (host_addr_i)
                `RTSB_OFF_STATUS: begin
                    rdata_reg <= status_reg;
                end
                `RTSB_OFF_CURMSG: begin
                    rdata_reg <= curmsg_reg;
                end
                `RTSB_OFF_BUSA: begin
                    rdata_reg <= busa_reg;
                end
                default: begin
                    rdata_reg <= '0;
                end
            endcase
        end
    end

    assign host_rdata_o = rdata_reg;
endmodule

// *** test/rtsb_props.sv ***
// concurrent checks on the ports of the status bits block
`timescale 1ns/10ps
module rtsb_props (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic terminal_soft_reset_i,
    input wire rtsb_pkg::rtsb_word_t host_addr_i,
    input wire logic host_wr_i,
    input wire rtsb_pkg::rtsb_word_t host_wdata_i,
    input wire logic vector_word_option_i,
    input wire logic auto_shutdown_disable_i,
    input wire logic busy_interrupt_option_i,
    input wire logic subsystem_fail_pin_i,
    input wire logic cmd_valid_i,
    input wire rtsb_pkg::rtsb_word_t cmd_buf_addr_i,
    input wire logic cmd_transmit_i,
    input wire logic cmd_is_mode_i,
    input wire rtsb_pkg::rtsb_mode_code_t mode_code_i,
    input wire logic cmd_on_bus_b_i,
    input wire logic desc_busy_i,
    input wire logic mode_data_valid_i,
    input wire rtsb_pkg::rtsb_word_t mode_data_i,
    input wire logic msg_done_i,
    input wire logic msg_broadcast_i,
    input wire logic msg_error_i,
    input wire logic [10:0] status_word_bits_o,
    input wire logic resp_busy_o,
    input wire logic suppress_data_o,
    input wire logic message_was_busy_flag_o,
    input wire logic irq_was_busy_flag_o,
    input wire logic tx_shutdown_a_flag_o,
    input wire rtsb_pkg::rtsb_word_t current_message_pointer_o
);
    import rtsb_pkg::*;
    logic [7:0] cnt;
    rtsb_word_t saved;
    rtsb_word_t sel;
    // cycles since the last valid command and its buffer address
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt <= 8'h00;
            saved <= 16'h0000;
        end else if (cmd_valid_i) begin
            cnt <= 8'h01;
            saved <= cmd_buf_addr_i;
        end else if (cnt != 8'h00 && cnt != 8'hff) begin
            cnt <= cnt + 8'h01;
        end
    end
    // shadow of the select register, kept over soft reset
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sel <= 16'h0000;
        end else if (host_wr_i && host_addr_i == 16'h001c) begin
            sel <= host_wdata_i;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // qualifying shutdown mode data word
    sequence s_hit(logic [4:0] c);
        mode_data_valid_i && cmd_is_mode_i && cmd_on_bus_b_i && !auto_shutdown_disable_i
            && mode_data_i == sel && mode_code_i == c;
    endsequence
    // pointer quiet at the last wait cycle, then loaded
    sequence s_load;
        $stable(current_message_pointer_o) ##1 current_message_pointer_o == saved;
    endsequence
    a_subsys_pin_or: assert property (
        subsystem_fail_pin_i |-> status_word_bits_o[2]) else $error("subsystem flag low");
    a_busy_status_bit: assert property (
        cmd_valid_i |=> status_word_bits_o[3] == $past(resp_busy_o))
        else $error("status busy bit wrong");
    a_desc_busy_resp: assert property (
        cmd_valid_i && desc_busy_i |-> resp_busy_o) else $error("descriptor busy lost");
    a_busy_tx_quiet: assert property (
        cmd_valid_i && desc_busy_i && cmd_transmit_i |-> suppress_data_o)
        else $error("busy transmit sent data");
    a_tflag_tx_quiet: assert property (
        cmd_valid_i && status_word_bits_o[0] && cmd_transmit_i && !cmd_is_mode_i
        |-> suppress_data_o) else $error("flagged transmit sent data");
    a_vector_clears_ssf: assert property (
        cmd_valid_i && cmd_is_mode_i && mode_code_i == 5'h10 && !vector_word_option_i
        && !host_wr_i |=> subsystem_fail_pin_i || !status_word_bits_o[2])
        else $error("vector command kept subsystem bit");
    a_ptr_load_delay: assert property (
        cnt == 8'd125 && !cmd_valid_i && !$past(host_wr_i) |-> s_load)
        else $error("pointer load time or value wrong");
    a_msg_result_bits: assert property (
        msg_done_i && !terminal_soft_reset_i |=> status_word_bits_o[4] == $past(msg_broadcast_i)
        && status_word_bits_o[10] == $past(msg_error_i)) else $error("message result bits");
    a_irq_busy_gate: assert property (
        msg_done_i |=> irq_was_busy_flag_o
        == (message_was_busy_flag_o && $past(busy_interrupt_option_i)))
        else $error("irq was-busy gating");
    a_shutdown_set: assert property (
        s_hit(5'h14) |=> tx_shutdown_a_flag_o) else $error("shutdown not set");
    a_override_clear: assert property (
        s_hit(5'h15) |=> !tx_shutdown_a_flag_o) else $error("shutdown not cleared");
    a_shutdown_hold: assert property (
        mode_data_valid_i && (!cmd_on_bus_b_i || auto_shutdown_disable_i || mode_data_i != sel)
        |=> $stable(tx_shutdown_a_flag_o)) else $error("shutdown flag moved");
endmodule
bind rtsb_top rtsb_props u_props (.*);

// *** test/rtsb_bc_model.sv ***
// bus controller model driving the command decode side
`timescale 1ns/10ps
module rtsb_bc_model (
    input wire logic clk_i,
    output logic cmd_valid_o,
    output rtsb_pkg::rtsb_word_t buf_addr_o,
    output logic transmit_o,
    output logic is_mode_o,
    output rtsb_pkg::rtsb_mode_code_t code_o,
    output logic bus_b_o,
    output logic desc_busy_o,
    output logic mdv_o,
    output rtsb_pkg::rtsb_word_t mdata_o,
    output logic sent_o,
    output logic rep_o,
    output logic done_o,
    output logic bcast_o,
    output logic err_o
);
    import rtsb_pkg::*;
    // quiet bus at start
    initial begin
        {cmd_valid_o, transmit_o, is_mode_o, bus_b_o, desc_busy_o} = 5'h00;
        {mdv_o, sent_o, rep_o, done_o, bcast_o, err_o} = 6'h00;
        {buf_addr_o, mdata_o, code_o} = 37'h0;
    end
    // command strobe; flags are transmit, mode, bus b, descriptor busy
    task automatic cmd(input rtsb_word_t a, input logic [3:0] f, input rtsb_mode_code_t c);
        @(negedge clk_i);
        {transmit_o, is_mode_o, bus_b_o, desc_busy_o} = f;
        code_o = c;
        buf_addr_o = a;
        cmd_valid_o = 1'b1;
    endtask
    // strobe dropped, stale address shows its inverse
    task automatic rel();
        @(negedge clk_i);
        cmd_valid_o = 1'b0;
        buf_addr_o = ~buf_addr_o;
    endtask
    // one mode data word
    task automatic mdata(input rtsb_word_t d);
        @(negedge clk_i);
        mdata_o = d;
        mdv_o = 1'b1;
        @(negedge clk_i);
        mdv_o = 1'b0;
        mdata_o = ~d;
    endtask
    // status sent and message closed; flags are repeat, broadcast, error
    task automatic done(input logic [2:0] f);
        @(negedge clk_i);
        {rep_o, bcast_o, err_o} = f;
        {sent_o, done_o} = 2'b11;
        @(negedge clk_i);
        {sent_o, done_o, rep_o, bcast_o, err_o} = 5'h00;
    endtask
endmodule

// *** test/rtsb_top_tb.sv ***
// self-checking bench for the status bits and bus select block
`timescale 1ns/10ps
module rtsb_top_tb;
    import rtsb_pkg::*;
    logic clk_i = 1'b0, reset_n_i = 1'b0, terminal_soft_reset_i = 1'b0;
    logic host_wr_i = 1'b0, host_rd_i = 1'b0, subsystem_fail_pin_i = 1'b0;
    logic vector_word_option_i = 1'b0, auto_shutdown_disable_i = 1'b0;
    logic busy_interrupt_option_i = 1'b0, rd_pend = 1'b0;
    rtsb_word_t host_addr_i = 16'h0000, host_wdata_i = 16'h0000;
    rtsb_word_t host_rdata_o, current_message_pointer_o, cmd_buf_addr_i, mode_data_i, p;
    logic cmd_valid_i, cmd_transmit_i, cmd_is_mode_i, cmd_on_bus_b_i, desc_busy_i;
    logic mode_data_valid_i, status_sent_i, status_repeat_i, msg_done_i;
    logic msg_broadcast_i, msg_error_i, resp_busy_o, suppress_data_o;
    logic message_was_busy_flag_o, irq_was_busy_flag_o, tx_shutdown_a_flag_o;
    rtsb_mode_code_t mode_code_i;
    logic [10:0] status_word_bits_o;
    logic [4:0] steps[5] = '{5'b01011, 5'b11001, 5'b10011, 5'b11111, 5'b11010};
    int n_errors = 0, check_count = 0;
    int unsigned r;
    rtsb_word_t exp_q[$];
    rtsb_top dut (.*);
    rtsb_bc_model bc (
        .clk_i(clk_i),
        .cmd_valid_o(cmd_valid_i),
        .buf_addr_o(cmd_buf_addr_i),
        .transmit_o(cmd_transmit_i),
        .is_mode_o(cmd_is_mode_i),
        .code_o(mode_code_i),
        .bus_b_o(cmd_on_bus_b_i),
        .desc_busy_o(desc_busy_i),
        .mdv_o(mode_data_valid_i),
        .mdata_o(mode_data_i),
        .sent_o(status_sent_i),
        .rep_o(status_repeat_i),
        .done_o(msg_done_i),
        .bcast_o(msg_broadcast_i),
        .err_o(msg_error_i)
    );
    always #20 clk_i = ~clk_i;
    task automatic check(input rtsb_word_t seen, input rtsb_word_t exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input rtsb_word_t a, input rtsb_word_t d);
        @(negedge clk_i);
        {host_addr_i, host_wdata_i, host_wr_i} = {a, d, 1'b1};
        @(negedge clk_i);
        host_wr_i = 1'b0;
    endtask
    task automatic rd(input rtsb_word_t a, input rtsb_word_t e);
        @(negedge clk_i);
        {host_addr_i, host_rd_i} = {a, 1'b1};
        exp_q.push_back(e);
        @(negedge clk_i);
        host_rd_i = 1'b0;
    endtask
    // read data against the oldest note
    always @(posedge clk_i) rd_pend <= host_rd_i;
    always @(negedge clk_i) begin
        if (rd_pend) check(host_rdata_o, exp_q.pop_front());
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #(40 * 3000);
        n_errors++;
        conclude();
    end
    initial begin
        r = $urandom(32'h6c966c9f);
        repeat (5) @(negedge clk_i);
        reset_n_i = 1'b1;
        rd(16'h001b, 16'h0000);
        rd(16'h001c, 16'h0000);
        rd(16'h001d, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            r = $urandom();
            wr(16'h001a, r[15:0]);
            rd(16'h001a, r[15:0] & 16'h830f);
            check({status_word_bits_o[10:4], status_word_bits_o[2:0]}, {1'b0, r[9:8], 4'h0, r[2:0]});
            wr(16'h001c, r[31:16]);
            rd(16'h001c, r[31:16]);
        end
        $display("register test done");
        for (int i = 0; i < 4; i++) begin
            wr(16'h001a, {12'h000, i[1], 3'b000});
            busy_interrupt_option_i = i[0];
            bc.cmd(16'h0100, {3'b100, i[0]}, 5'h00);
            #1;
            check(resp_busy_o, i[1] | i[0]);
            check(suppress_data_o, i[1] | i[0]);
            bc.rel();
            bc.done(3'b000);
            check(message_was_busy_flag_o, i[1] | i[0]);
            check(irq_was_busy_flag_o, i[0]);
        end
        wr(16'h001a, 16'h0001);
        for (int m = 0; m < 2; m++) begin
            bc.cmd(16'h0300, {1'b1, m[0], 2'b00}, 5'h12);
            #1;
            check(suppress_data_o, 1'b1);
            bc.rel();
        end
        subsystem_fail_pin_i = 1'b1;
        #1 check(status_word_bits_o[2], 1'b1);
        @(negedge clk_i);
        subsystem_fail_pin_i = 1'b0;
        for (int v = 0; v < 2; v++) begin
            vector_word_option_i = v[0];
            wr(16'h001a, 16'h0004);
            bc.cmd(16'h0400, 4'b0100, 5'h10);
            bc.rel();
            rd(16'h001a, {13'h0000, v[0], 2'b00});
        end
        $display("status bit test done");
        repeat (130) @(negedge clk_i);
        r = $urandom();
        p = r[31:16];
        wr(16'h001b, r[15:0]);
        bc.cmd(p, 4'b0000, 5'h00);
        bc.rel();
        repeat (124) @(negedge clk_i);
        check(current_message_pointer_o, r[15:0]);
        @(negedge clk_i);
        check(current_message_pointer_o, p);
        wr(16'h001c, p);
        foreach (steps[i]) begin
            auto_shutdown_disable_i = steps[i][2];
            bc.cmd(16'h0500, {2'b01, steps[i][3], 1'b0}, {4'ha, steps[i][4]});
            bc.rel();
            bc.mdata(steps[i][1] ? p : ~p);
            check(tx_shutdown_a_flag_o, steps[i][0]);
        end
        $display("pointer and shutdown test done");
        repeat (130) @(negedge clk_i);
        wr(16'h001a, 16'h830f);
        bc.done(3'b100);
        rd(16'h001a, 16'h830f);
        bc.done(3'b010);
        rd(16'h001a, 16'h0010);
        bc.done(3'b001);
        rd(16'h001a, 16'h0400);
        terminal_soft_reset_i = 1'b1;
        @(negedge clk_i);
        terminal_soft_reset_i = 1'b0;
        rd(16'h001b, 16'h0500);
        rd(16'h001c, p);
        reset_n_i = 1'b0;
        repeat (2) @(negedge clk_i);
        reset_n_i = 1'b1;
        rd(16'h001b, 16'h0000);
        rd(16'h001c, 16'h0000);
        $display("clear and reset test done");
        conclude();
    end
endmodule
